// ### mio_pin_model.sv
// Purpose: pin-side circuitry seen by the three-port i/o block
// Assumes: one clock; outside drivers per line enabled by the bench
// Notes: an undriven line without pull-up shows the inverse of its last level
module mio_pin_model (
  input wire logic clock,
  input wire logic [7:0] p0_out,
  input wire logic [7:0] p0_oe,
  input wire logic [7:0] p0_pu,
  input wire logic [7:0] p0_ext_en,
  input wire logic [7:0] p0_ext,
  input wire logic [7:0] p2_out,
  input wire logic [7:0] p2_oe,
  input wire logic [7:0] p2_pu,
  input wire logic [7:0] p2_ext_en,
  input wire logic [7:0] p2_ext,
  output logic [7:0] p0_pin,
  output logic [7:0] p2_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] p0_last_q = 8'h00;
  logic [7:0] p2_last_q = 8'h00;
  function automatic logic [7:0] resolve(input logic [7:0] o, oe, pu, en, ext, last);
    for (int i = 0; i < 8; i++) begin
      resolve[i] = oe[i] ? o[i] : en[i] ? ext[i] : pu[i] ? 1'b1 : ~last[i];
    end
  endfunction
  assign p0_pin = resolve(p0_out, p0_oe, p0_pu, p0_ext_en, p0_ext, p0_last_q);
  assign p2_pin = resolve(p2_out, p2_oe, p2_pu, p2_ext_en, p2_ext, p2_last_q);
  always_ff @(posedge clock) begin
    p0_last_q <= p0_pin;
    p2_last_q <= p2_pin;
  end
endmodule

// ### mio_pkg.sv
// Purpose: shared constants for the three-port i/o block
// Assumes: single 25 MHz clock, byte-wide register port
// Notes: offsets are word indices on the plain register port
package mio_pkg;
  localparam logic [3:0] OFF_CFG = 4'h0;
  localparam logic [3:0] OFF_P0_MODE = 4'h1;
  localparam logic [3:0] OFF_P0_DATA = 4'h2;
  localparam logic [3:0] OFF_P2_DIR = 4'h3;
  localparam logic [3:0] OFF_P2_DATA = 4'h4;
  localparam logic [3:0] OFF_P3_DATA = 4'h5;
  localparam logic [3:0] OFF_WAKE_SEL = 4'h6;
  localparam logic [3:0] OFF_WAKE_CTL = 4'h7;
  localparam logic [3:0] OFF_IRQ_STAT = 4'h8;
  localparam logic [3:0] OFF_IRQ_MASK = 4'h9;
  localparam logic [3:0] OFF_P3_CTL = 4'ha;
  localparam int CFG_P0_OD_BIT = 2;
  localparam int CFG_P2_OD_BIT = 1;
  localparam int CFG_EDGE_SEL_BIT = 0;
  localparam int WCTL_OR_EN_BIT = 0;
  localparam int WCTL_AND_EN_BIT = 1;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [1:0] P0_MODE_RST = 2'h0;
  localparam logic [7:0] P2_DIR_RST = 8'h00;
  localparam logic [1:0] WAKE_CTL_RST = 2'h0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [3:0] NIB_ZERO = 4'h0;
endpackage

// ### mio_ports.sv
// Purpose: three general-purpose i/o ports with wake-up gates and pin interrupts
// Assumes: pins synchronous-ish, sampled through two flops; one clock domain
// Notes: pull-up straps are build-time parameters
// Overview of operation
// - first port is eight lines, direction set per nibble only.
// - one config bit picks push-pull or open-drain for first port.
// - first port must be set up before output; reset leaves inputs.
// - first port pull-ups are a build option, per nibble.
// - pull-up switched off on any line acting as output.
// - stop-mode recovery returns first port direction to input.
// - second port lines each set independently as input or output.
// - one common push-pull or open-drain choice for second port outputs.
// - power-on reset makes all second port lines inputs.
// - second port pull-ups are a build option for all eight lines.
// - second port inputs feed OR and AND gates that can wake.
// - software can route lowest second port line to edge detection.
// - third port low half fixed inputs, high half fixed push-pull outputs.
// - third port inputs can interrupt; outputs can carry timer signals.
// - output lines are dropped from wake gates; rest still evaluated.
//
// Our own choices: the strobed register port and the register offsets.
module mio_ports
  import mio_pkg::*;
#(
  parameter logic [1:0] P0_PULLUP_OPT = 2'h0,
  parameter logic P2_PULLUP_OPT = 1'b0
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic stop_recovery,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] first_port_lines_in,
  output logic [7:0] first_port_lines_out,
  output logic [7:0] first_port_lines_oe,
  output logic [7:0] first_port_pullup_en,
  input wire logic [7:0] second_port_lines_in,
  output logic [7:0] second_port_lines_out,
  output logic [7:0] second_port_lines_oe,
  output logic [7:0] second_port_pullup_en,
  input wire logic [3:0] third_port_inputs,
  output logic [3:0] third_port_outputs,
  input wire logic [3:0] timer_out,
  output logic edge_detect_input_line,
  output logic wake_request,
  output logic irq
);
  logic [7:0] cfg_q, cfg_d;
  logic [1:0] p0_mode_q, p0_mode_d;
  logic [7:0] p0_data_q, p0_data_d;
  logic [7:0] p2_dir_q, p2_dir_d;
  logic [7:0] p2_data_q, p2_data_d;
  logic [3:0] p3_data_q, p3_data_d;
  logic [3:0] p3_ctl_q, p3_ctl_d;
  logic [7:0] wake_sel_q, wake_sel_d;
  logic [1:0] wake_ctl_q, wake_ctl_d;
  logic [3:0] stat_q, stat_d;
  logic [3:0] mask_q, mask_d;
  logic [3:0] p3_prev_q, p3_prev_d;
  logic [7:0] rdata_q, rdata_d;
  logic [7:0] p0_sync, p2_sync;
  logic [3:0] p3_sync;
  logic [7:0] p0_oe, p2_active;
  logic or_wake, and_wake;

  function automatic logic wr_hit(input logic [3:0] off);
    wr_hit = reg_wr && (reg_addr == off);
  endfunction

  // pins pass two flops before any use
  mio_sync #(.W(8)) u_sync0 (.clock(clock), .reset(reset), .din(first_port_lines_in), .dout(p0_sync));
  mio_sync #(.W(8)) u_sync2 (.clock(clock), .reset(reset), .din(second_port_lines_in), .dout(p2_sync));
  mio_sync #(.W(4)) u_sync3 (.clock(clock), .reset(reset), .din(third_port_inputs), .dout(p3_sync));

  always_comb begin
    cfg_d = cfg_q;
    p0_mode_d = p0_mode_q;
    p0_data_d = p0_data_q;
    p2_dir_d = p2_dir_q;
    p2_data_d = p2_data_q;
    p3_data_d = p3_data_q;
    p3_ctl_d = p3_ctl_q;
    wake_sel_d = wake_sel_q;
    wake_ctl_d = wake_ctl_q;
    mask_d = mask_q;
    if (wr_hit(OFF_CFG)) begin
      cfg_d = reg_wdata;
    end
    if (wr_hit(OFF_P0_MODE)) begin
      p0_mode_d = reg_wdata[1:0];
    end
    if (stop_recovery) begin
      p0_mode_d = P0_MODE_RST;
    end
    if (wr_hit(OFF_P0_DATA)) begin
      p0_data_d = reg_wdata;
    end
    if (wr_hit(OFF_P2_DIR)) begin
      p2_dir_d = reg_wdata;
    end
    if (wr_hit(OFF_P2_DATA)) begin
      p2_data_d = reg_wdata;
    end
    if (wr_hit(OFF_P3_DATA)) begin
      p3_data_d = reg_wdata[7:4];
    end
    if (wr_hit(OFF_P3_CTL)) begin
      p3_ctl_d = reg_wdata[3:0];
    end
    if (wr_hit(OFF_WAKE_SEL)) begin
      wake_sel_d = reg_wdata;
    end
    if (wr_hit(OFF_WAKE_CTL)) begin
      wake_ctl_d = reg_wdata[1:0];
    end
    if (wr_hit(OFF_IRQ_MASK)) begin
      mask_d = reg_wdata[3:0];
    end
  end

  // falling edge on a third-port input latches a sticky flag; set beats clear
  always_comb begin
    p3_prev_d = p3_sync;
    stat_d = stat_q;
    if (wr_hit(OFF_IRQ_STAT)) begin
      stat_d = stat_q & ~reg_wdata[3:0];
    end
    stat_d = stat_d | (p3_prev_q & ~p3_sync);
  end

  always_comb begin
    rdata_d = BYTE_ZERO;
    if (reg_rd) begin
      unique case (reg_addr)
        OFF_CFG: rdata_d = cfg_q;
        OFF_P0_MODE: rdata_d = {6'h00, p0_mode_q};
        OFF_P0_DATA: rdata_d = p0_sync;
        OFF_P2_DIR: rdata_d = p2_dir_q;
        OFF_P2_DATA: rdata_d = p2_sync;
        OFF_P3_DATA: rdata_d = {p3_data_q, p3_sync};
        OFF_WAKE_SEL: rdata_d = wake_sel_q;
        OFF_WAKE_CTL: rdata_d = {6'h00, wake_ctl_q};
        OFF_IRQ_STAT: rdata_d = {4'h0, stat_q};
        OFF_IRQ_MASK: rdata_d = {4'h0, mask_q};
        OFF_P3_CTL: rdata_d = {4'h0, p3_ctl_q};
        default: rdata_d = BYTE_ZERO;
      endcase
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cfg_q <= CFG_RST;
      p0_mode_q <= P0_MODE_RST;
      p0_data_q <= BYTE_ZERO;
      p2_dir_q <= P2_DIR_RST;
      p2_data_q <= BYTE_ZERO;
      p3_data_q <= NIB_ZERO;
      p3_ctl_q <= NIB_ZERO;
      wake_sel_q <= BYTE_ZERO;
      wake_ctl_q <= WAKE_CTL_RST;
      stat_q <= NIB_ZERO;
      mask_q <= NIB_ZERO;
      p3_prev_q <= NIB_ZERO;
      rdata_q <= BYTE_ZERO;
    end else begin
      cfg_q <= cfg_d;
      p0_mode_q <= p0_mode_d;
      p0_data_q <= p0_data_d;
      p2_dir_q <= p2_dir_d;
      p2_data_q <= p2_data_d;
      p3_data_q <= p3_data_d;
      p3_ctl_q <= p3_ctl_d;
      wake_sel_q <= wake_sel_d;
      wake_ctl_q <= wake_ctl_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      p3_prev_q <= p3_prev_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign p0_oe = {{4{p0_mode_q[1]}}, {4{p0_mode_q[0]}}};

  // open-drain drives only a low; high is released
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      first_port_lines_out[i] = p0_data_q[i];
      first_port_lines_oe[i] = p0_oe[i] && !(cfg_q[CFG_P0_OD_BIT] && p0_data_q[i]);
      second_port_lines_out[i] = p2_data_q[i];
      second_port_lines_oe[i] = p2_dir_q[i] && !(cfg_q[CFG_P2_OD_BIT] && p2_data_q[i]);
      first_port_pullup_en[i] = P0_PULLUP_OPT[i/4] && !p0_oe[i];
      second_port_pullup_en[i] = P2_PULLUP_OPT && !p2_dir_q[i];
    end
  end

  // outputs ignored, unselected inputs neutral to each gate
  assign p2_active = wake_sel_q & ~p2_dir_q;
  assign or_wake = |(p2_sync & p2_active);
  assign and_wake = (p2_active != BYTE_ZERO) && ((p2_sync | ~p2_active) == 8'hff);
  assign wake_request = (wake_ctl_q[WCTL_OR_EN_BIT] && or_wake) || (wake_ctl_q[WCTL_AND_EN_BIT] && and_wake);

  assign edge_detect_input_line = cfg_q[CFG_EDGE_SEL_BIT] && p2_sync[0];

  always_comb begin
    for (int j = 0; j < 4; j++) begin
      third_port_outputs[j] = p3_ctl_q[j] ? timer_out[j] : p3_data_q[j];
    end
  end

  assign irq = |(stat_q & mask_q);

  property p_p0_recover;
    @(posedge clock) disable iff (reset) stop_recovery |=> (first_port_lines_oe == 8'h00);
  endproperty
  a_p0_recover: assert property (p_p0_recover) else $error("first port not input after recovery");

  property p_p0_nibble;
    @(posedge clock) disable iff (reset)
      (first_port_lines_oe[3:0] != 4'h0) |-> p0_mode_q[0];
  endproperty
  a_p0_nibble: assert property (p_p0_nibble) else $error("low nibble driven while input");

  property p_pullup_off;
    @(posedge clock) disable iff (reset)
      ((second_port_pullup_en & p2_dir_q) == 8'h00) && ((first_port_pullup_en & p0_oe) == 8'h00);
  endproperty
  a_pullup_off: assert property (p_pullup_off) else $error("pull-up on output line");

  property p_od_high;
    @(posedge clock) disable iff (reset)
      cfg_q[CFG_P2_OD_BIT] |-> ((second_port_lines_oe & p2_data_q) == 8'h00);
  endproperty
  a_od_high: assert property (p_od_high) else $error("open-drain drove a high");

  property p_sync_read;
    @(posedge clock) disable iff (reset)
      (reg_rd && reg_addr == OFF_P2_DATA) |=> (reg_rdata == $past(p2_sync));
  endproperty
  a_sync_read: assert property (p_sync_read) else $error("port read mismatch");

  property p_wake_out;
    @(posedge clock) disable iff (reset)
      (wake_ctl_q[WCTL_OR_EN_BIT] && (p2_dir_q == 8'hff)) |-> !or_wake;
  endproperty
  a_wake_out: assert property (p_wake_out) else $error("output line woke the part");

  property p_edge_route;
    @(posedge clock) disable iff (reset)
      !cfg_q[CFG_EDGE_SEL_BIT] |-> !edge_detect_input_line;
  endproperty
  a_edge_route: assert property (p_edge_route) else $error("edge path not gated");

  property p_irq_set;
    @(posedge clock) disable iff (reset)
      (p3_prev_q[0] && !p3_sync[0]) |=> stat_q[0];
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("third port edge lost");

  property p_dir_write;
    @(posedge clock) disable iff (reset)
      (reg_wr && reg_addr == OFF_P2_DIR) |=> (p2_dir_q == $past(reg_wdata));
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction write lost");

  property p_stat_sticky;
    @(posedge clock) disable iff (reset)
      !(reg_wr && reg_addr == OFF_IRQ_STAT) |=> ((stat_q & $past(stat_q)) == $past(stat_q));
  endproperty
  a_stat_sticky: assert property (p_stat_sticky) else $error("status bit lost without clear");

  property p_stat_clear;
    @(posedge clock) disable iff (reset)
      (reg_wr && reg_addr == OFF_IRQ_STAT && reg_wdata[0] && !(p3_prev_q[0] && !p3_sync[0])) |=> !stat_q[0];
  endproperty
  a_stat_clear: assert property (p_stat_clear) else $error("status bit not cleared");

  property p_p3_fixed;
    @(posedge clock) disable iff (reset)
      (p3_ctl_q == 4'h0) |-> (third_port_outputs == p3_data_q);
  endproperty
  a_p3_fixed: assert property (p_p3_fixed) else $error("third port output not from data");

  property p_p2_push;
    @(posedge clock) disable iff (reset)
      !cfg_q[CFG_P2_OD_BIT] |-> (second_port_lines_oe == p2_dir_q);
  endproperty
  a_p2_push: assert property (p_p2_push) else $error("second port push-pull enable wrong");

  property p_p0_od_high;
    @(posedge clock) disable iff (reset)
      cfg_q[CFG_P0_OD_BIT] |-> ((first_port_lines_oe & p0_data_q) == 8'h00);
  endproperty
  a_p0_od_high: assert property (p_p0_od_high) else $error("first port open-drain drove a high");

  property p_p0_push;
    @(posedge clock) disable iff (reset)
      !cfg_q[CFG_P0_OD_BIT] |-> (first_port_lines_oe == p0_oe);
  endproperty
  a_p0_push: assert property (p_p0_push) else $error("first port push-pull enable wrong");

  property p_wake_and;
    @(posedge clock) disable iff (reset)
      (wake_ctl_q[WCTL_AND_EN_BIT] && (p2_active != 8'h00) && ((p2_sync & p2_active) == p2_active)) |-> wake_request;
  endproperty
  a_wake_and: assert property (p_wake_and) else $error("and gate wake missed");

  property p_edge_follow;
    @(posedge clock) disable iff (reset)
      cfg_q[CFG_EDGE_SEL_BIT] |-> (edge_detect_input_line == p2_sync[0]);
  endproperty
  a_edge_follow: assert property (p_edge_follow) else $error("edge path does not follow line");
endmodule

// ### mio_sync.sv
// Purpose: two-flop synchroniser for a bus of pin levels
// Assumes: reset is asynchronous, active high
// Notes: first stage feeds only the second
module mio_sync #(parameter int W = 8) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
    end
  end
  assign dout = s2_q;
endmodule

// ### tb_top.sv
// Purpose: self-checking bench for the three-port i/o block
// Assumes: pull-up options high nibble on first port, all on second
// Notes: table rows cover configuration; pins, wake and irq hand-written
module tb_top
  import mio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [3:0] a; logic [7:0] d, oe0, oe2, pu0, pu2;} mio_row_t;
  localparam mio_row_t ROWS [8] = '{
    '{OFF_P0_MODE, 8'h01, 8'h0f, 8'h00, 8'hf0, 8'hff}, '{OFF_P0_MODE, 8'h02, 8'hf0, 8'h00, 8'h00, 8'hff},
    '{OFF_P0_MODE, 8'h03, 8'hff, 8'h00, 8'h00, 8'hff}, '{OFF_P0_DATA, 8'ha5, 8'hff, 8'h00, 8'h00, 8'hff},
    '{OFF_CFG, 8'h04, 8'h5a, 8'h00, 8'h00, 8'hff}, '{OFF_P2_DIR, 8'h3c, 8'h5a, 8'h3c, 8'h00, 8'hc3},
    '{OFF_P2_DATA, 8'h0f, 8'h5a, 8'h3c, 8'h00, 8'hc3}, '{OFF_CFG, 8'h02, 8'hff, 8'h30, 8'h00, 8'hc3}};
  logic clock, reset, stop_recovery, reg_wr, reg_rd, edge_detect_input_line, wake_request, irq;
  logic [3:0] reg_addr, third_port_inputs, third_port_outputs, timer_out;
  logic [7:0] reg_wdata, reg_rdata, p0_in, p0_out, p0_oe, p0_pu, p2_in, p2_out, p2_oe, p2_pu, p2_ext, rv;
  int mismatches = 0;
  int n_tests = 0;
  mio_ports #(.P0_PULLUP_OPT(2'h2), .P2_PULLUP_OPT(1'b1)) uut (.clock(clock), .reset(reset),
    .stop_recovery(stop_recovery), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .first_port_lines_in(p0_in), .first_port_lines_out(p0_out),
    .first_port_lines_oe(p0_oe), .first_port_pullup_en(p0_pu), .second_port_lines_in(p2_in),
    .second_port_lines_out(p2_out), .second_port_lines_oe(p2_oe), .second_port_pullup_en(p2_pu),
    .third_port_inputs(third_port_inputs), .third_port_outputs(third_port_outputs), .timer_out(timer_out),
    .edge_detect_input_line(edge_detect_input_line), .wake_request(wake_request), .irq(irq));
  mio_pin_model pins (.clock(clock), .p0_out(p0_out), .p0_oe(p0_oe), .p0_pu(p0_pu), .p0_ext_en(8'hff),
    .p0_ext(8'h3c), .p2_out(p2_out), .p2_oe(p2_oe), .p2_pu(p2_pu), .p2_ext_en(8'hff), .p2_ext(p2_ext),
    .p0_pin(p0_in), .p2_pin(p2_in));
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("FAIL %s expected %h seen %h", name, exp, got);
      mismatches++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic p2_set(input logic [7:0] v);
    @(posedge clock);
    p2_ext <= v;
    cyc(3);
  endtask
  task automatic close_out;
    $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    repeat (3000) @(posedge clock);
    mismatches++;
    close_out;
  end
  initial begin
    reset = 1'b1; stop_recovery = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 4'h0;
    reg_wdata = 8'h00; third_port_inputs = 4'hf; timer_out = 4'h3; p2_ext = 8'h00;
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    cyc(1);
    chk("p0_oe", 8'h00, p0_oe);
    chk("p2_oe", 8'h00, p2_oe);
    chk("p0_pu", 8'hf0, p0_pu);
    chk("irq", 8'h00, {7'h0, irq});
    foreach (ROWS[i]) begin
      wr(ROWS[i].a, ROWS[i].d);
      chk("p0_oe", ROWS[i].oe0, p0_oe);
      chk("p2_oe", ROWS[i].oe2, p2_oe);
      chk("p0_pu", ROWS[i].pu0, p0_pu);
      chk("p2_pu", ROWS[i].pu2, p2_pu);
    end
    chk("p0_out", 8'ha5, p0_out);
    @(posedge clock);
    stop_recovery <= 1'b1;
    @(posedge clock);
    stop_recovery <= 1'b0;
    cyc(1);
    chk("p0_oe", 8'h00, p0_oe);
    chk("p0_pu", 8'hf0, p0_pu);
    chk("p2_oe", 8'h30, p2_oe);
    rd(OFF_P0_DATA, rv);
    chk("p0_rd", 8'h3c, rv);
    wr(OFF_CFG, 8'h00);
    wr(OFF_P2_DIR, 8'h00);
    p2_set(8'ha6);
    rd(OFF_P2_DATA, rv);
    chk("p2_rd", 8'ha6, rv);
    cyc(1);
    chk("rdata_idle", 8'h00, reg_rdata);
    @(posedge clock);
    p2_ext <= 8'h5b;
    rd(OFF_P2_DATA, rv);
    chk("p2_rd_old", 8'ha6, rv);
    rd(OFF_P2_DATA, rv);
    chk("p2_rd_new", 8'h5b, rv);
    wr(OFF_CFG, 8'h01);
    cyc(1);
    chk("edge_on", 8'h01, {7'h0, edge_detect_input_line});
    wr(OFF_CFG, 8'h00);
    cyc(1);
    chk("edge_off", 8'h00, {7'h0, edge_detect_input_line});
    wr(OFF_WAKE_SEL, 8'h0f);
    wr(OFF_WAKE_CTL, 8'h01);
    p2_set(8'hf0);
    chk("wake_or0", 8'h00, {7'h0, wake_request});
    p2_set(8'hf1);
    chk("wake_or1", 8'h01, {7'h0, wake_request});
    wr(OFF_WAKE_CTL, 8'h02);
    p2_set(8'h0f);
    chk("wake_and1", 8'h01, {7'h0, wake_request});
    p2_set(8'h0e);
    chk("wake_and0", 8'h00, {7'h0, wake_request});
    wr(OFF_P2_DATA, 8'h0e);
    chk("p2_out", 8'h0e, p2_out);
    wr(OFF_P2_DIR, 8'h01);
    cyc(3);
    chk("wake_excl", 8'h01, {7'h0, wake_request});
    wr(OFF_IRQ_MASK, 8'h01);
    @(posedge clock);
    third_port_inputs <= 4'hc;
    cyc(5);
    chk("irq_set", 8'h01, {7'h0, irq});
    rd(OFF_IRQ_STAT, rv);
    chk("irq_stat", 8'h03, rv);
    wr(OFF_IRQ_STAT, 8'h01);
    chk("irq_masked", 8'h00, {7'h0, irq});
    rd(OFF_IRQ_STAT, rv);
    chk("irq_stat2", 8'h02, rv);
    wr(OFF_P3_DATA, 8'ha0);
    wr(OFF_P3_CTL, 8'hcc);
    chk("p3_out", 8'h02, {4'h0, third_port_outputs});
    rd(OFF_P3_DATA, rv);
    chk("p3_rd", 8'hac, rv);
    rd(4'hf, rv);
    chk("unmapped", 8'h00, rv);
    @(posedge clock);
    reset <= 1'b1;
    cyc(1);
    chk("p2_oe_rst", 8'h00, p2_oe);
    chk("p3_out_rst", 8'h00, {4'h0, third_port_outputs});
    @(posedge clock);
    reset <= 1'b0;
    cyc(4);
    rd(OFF_IRQ_STAT, rv);
    chk("stat_rst", 8'h00, rv);
    close_out;
  end
endmodule
